// ===== logic/clock_stop_monitor_pkg.sv
/*
  Package for the clock-stop monitor: register address, field positions,
  reset values, timing counts and shared types.
  Assumes a byte-wide internal register port and one 125 MHz system clock.
*/
package clock_stop_monitor_pkg;

  // ==========================================================================
  // register map
  localparam logic [15:0] mode_addr        = 16'hffa9;
  localparam logic [7:0]  mode_reset       = 8'h00;
  localparam int          enable_bit       = 0;
  localparam int          cause_monitor_bit = 1;
  localparam logic [7:0]  cause_reset      = 8'h00;

  // ==========================================================================
  // timing: default stabilization code and sampling window
  localparam logic [2:0]  stab_code_default = 3'h5;
  localparam int          stab_base_log2    = 11;  // code 1 gives 2^11 cycles
  localparam int          loss_ring_cycles  = 4;   // ring cycles with no edge

  // ==========================================================================
  // monitor states
  typedef enum logic [1:0] {
    mon_idle    = 2'b00,
    mon_wait    = 2'b01,
    mon_active  = 2'b10
  } mon_state_type;

  // write request from the cpu side
  typedef struct packed {
    logic        wr;
    logic        bit_mode;   // single-bit access
    logic [2:0]  bit_sel;
    logic [15:0] addr;
    logic [7:0]  data;
  } reg_write_type;

  // clock and power status inputs
  typedef struct packed {
    logic stop_mode;
    logic main_osc_stop_bit;
    logic main_clock_stop_control;
    logic ring_stop_bit;
    logic stab_done;
  } clock_status_type;

endpackage : clock_stop_monitor_pkg

// ===== logic/x1_edge_detector.sv
/*
  Loss detector: samples the main oscillator clock with the ring clock
  enable and flags loss after a fixed count of ring cycles with no edge.
  Assumes osc_i is asynchronous; it is synchronised here.
*/
`timescale 1ns/1ps
module x1_edge_detector (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ring_tick_i,
  input  wire logic run_i,
  input  wire logic osc_i,
  output logic      lost_o
);

  logic       sync1_reg, sync2_reg, last_reg, lost_reg;
  logic       last_next, lost_next;
  logic [3:0] cnt_reg, cnt_next;

  // ==========================================================================
  // two-flop synchroniser, the first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= osc_i;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================================
  // count ring ticks since the last observed transition
  always_comb begin
    cnt_next  = cnt_reg;
    last_next = last_reg;
    lost_next = 1'b0;
    if (!run_i) begin
      cnt_next  = 4'h0;
      last_next = sync2_reg;
    end else if (ring_tick_i) begin
      last_next = sync2_reg;
      if (sync2_reg != last_reg) begin
        cnt_next = 4'h0;
      end else if (cnt_reg ==
                   4'(clock_stop_monitor_pkg::loss_ring_cycles - 1)) begin
        lost_next = 1'b1;
        cnt_next  = 4'h0;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 4'h0;
      last_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      last_reg <= last_next;
      lost_reg <= lost_next;
    end
  end

  assign lost_o = lost_reg;

endmodule : x1_edge_detector

// ===== logic/clock_stop_monitor.sv
/*
  Clock-stop monitor top: mode register, pause logic, reset request and the
  monitor cause flag of the reset-cause register.
  Assumes the chip reset generator feeds rst_i (external pin reset) and
  int_rst_i, and that stabilization completion comes from the osc counter.
*/
`timescale 1ns/1ps
module clock_stop_monitor #(
  parameter bit RING_STOPPABLE = 1'b0,
  parameter int RING_DIV       = 4   // system cycles per ring sample
) (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_i,
  input  wire logic                                    int_rst_i,
  input  wire logic                                    poc_rst_i,
  input  wire logic                                    main_osc_clock_i,
  input  wire clock_stop_monitor_pkg::reg_write_type   wr_i,
  input  wire logic [15:0]                             rd_addr_i,
  input  wire clock_stop_monitor_pkg::clock_status_type status_i,
  output logic [7:0]                                   rd_data_o,
  output logic                                         monitor_enable_o,
  output logic                                         monitoring_o,
  output logic                                         monitor_reset_o,
  output logic                                         monitor_reset_cause_flag_o,
  output logic                                         ring_running_o
);


  // ==========================================================================
  // local state
  // every register has its next value beside it; one always_comb per group, two for the
  // mode register and cause flag, computes the next values and one always_ff only registers them

  // ring clock divider
  logic [7:0] ring_cnt_reg;
  logic [7:0] ring_cnt_next;
  logic       ring_tick_reg;
  logic       ring_tick_next;
  logic       ring_running_reg;
  logic       ring_running_next;

  // mode register and reset-cause flag
  logic       enable_reg;
  logic       enable_next;
  logic       cause_reg;
  logic       cause_next;

  // monitor sequencing
  clock_stop_monitor_pkg::mon_state_type state_reg;
  clock_stop_monitor_pkg::mon_state_type state_next;
  logic       monitoring_reg;
  logic       monitoring_next;
  logic       monitor_reset_reg;
  logic       monitor_reset_next;

  // register read port
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // combinational helpers
  logic       paused;
  logic       set_request;
  logic       clear_request;
  logic       lost;

  // ==========================================================================
  // write decoding

  // true when a write lands on the mode register
  function automatic logic hits_mode(
    input clock_stop_monitor_pkg::reg_write_type w
  );
    hits_mode = w.wr && (w.addr == clock_stop_monitor_pkg::mode_addr);
  endfunction : hits_mode

  // value carried to the enable bit by a byte or a single-bit write;
  // a single-bit write to any other bit position carries nothing
  function automatic logic enable_value(
    input clock_stop_monitor_pkg::reg_write_type w
  );
    logic sel_hit;
    sel_hit = (w.bit_sel == 3'(clock_stop_monitor_pkg::enable_bit));
    if (w.bit_mode) begin
      enable_value = sel_hit && w.data[0];
    end else begin
      enable_value = w.data[clock_stop_monitor_pkg::enable_bit];
    end
  endfunction : enable_value

  // ==========================================================================
  // ring oscillator stand-in
  // the ring clock is modelled as a one-cycle tick every RING_DIV system
  // cycles; stopping it only works when the build option allows it
  always_comb begin
    ring_running_next = 1'b1;
    if (RING_STOPPABLE) begin
      ring_running_next = !status_i.ring_stop_bit;
    end
    ring_cnt_next  = ring_cnt_reg;
    ring_tick_next = 1'b0;
    if (!ring_running_reg) begin
      ring_cnt_next = 8'h00;
    end else if (ring_cnt_reg == 8'(RING_DIV - 1)) begin
      ring_cnt_next  = 8'h00;
      ring_tick_next = 1'b1;
    end else begin
      ring_cnt_next = ring_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_cnt_reg     <= 8'h00;
      ring_tick_reg    <= 1'b0;
      ring_running_reg <= 1'b1;
    end else begin
      ring_cnt_reg     <= ring_cnt_next;
      ring_tick_reg    <= ring_tick_next;
      ring_running_reg <= ring_running_next;
    end
  end

  // ==========================================================================
  // pause conditions
  // any one of these suspends sampling; stabilization done is low during
  // the settling time after reset, after STOP and after a software stop
  assign paused = status_i.stop_mode
                | status_i.main_osc_stop_bit
                | status_i.main_clock_stop_control
                | !status_i.stab_done
                | !ring_running_reg;

  // ==========================================================================
  // mode register
  // the enable bit can only be set by software; any internal reset or the
  // monitor's own reset clears it, and a clear beats a write in one cycle
  assign set_request   = hits_mode(wr_i) && enable_value(wr_i);
  assign clear_request = int_rst_i | poc_rst_i | monitor_reset_reg;

  always_comb begin
    enable_next = enable_reg;
    if (set_request) begin
      enable_next = 1'b1;
    end
    if (clear_request) begin
      enable_next = 1'b0;
    end
  end

  // ==========================================================================
  // reset-cause flag of the monitor
  // power-on clear wipes it; a monitor reset in the same cycle wins so that
  // the cause of the newer reset is never lost
  always_comb begin
    cause_next = cause_reg;
    if (poc_rst_i) begin
      cause_next = 1'b0;
    end
    if (monitor_reset_reg) begin
      cause_next = 1'b1;
    end
  end

  // pin reset clears both the mode register and the cause flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= clock_stop_monitor_pkg::mode_reset[
                      clock_stop_monitor_pkg::enable_bit];
      cause_reg  <= clock_stop_monitor_pkg::cause_reset[
                      clock_stop_monitor_pkg::cause_monitor_bit];
    end else begin
      enable_reg <= enable_next;
      cause_reg  <= cause_next;
    end
  end

  // ==========================================================================
  // monitor sequencing
  // idle: enable clear; wait: enabled but paused; active: sampling.
  // waiting rather than dropping back to idle is what makes monitoring
  // restart by itself once a pause ends
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      clock_stop_monitor_pkg::mon_idle: begin
        if (enable_reg && paused) begin
          state_next = clock_stop_monitor_pkg::mon_wait;
        end else if (enable_reg) begin
          state_next = clock_stop_monitor_pkg::mon_active;
        end
      end
      clock_stop_monitor_pkg::mon_wait: begin
        if (!paused) begin
          state_next = clock_stop_monitor_pkg::mon_active;
        end
      end
      clock_stop_monitor_pkg::mon_active: begin
        if (paused) begin
          state_next = clock_stop_monitor_pkg::mon_wait;
        end else if (lost) begin
          state_next = clock_stop_monitor_pkg::mon_idle;
        end
      end
      default: begin
        state_next = clock_stop_monitor_pkg::mon_idle; // code 2'b11 illegal
      end
    endcase
    if (!enable_next) begin
      state_next = clock_stop_monitor_pkg::mon_idle;
    end
    monitoring_next = (state_next == clock_stop_monitor_pkg::mon_active);
    // a loss seen in the cycle a pause begins is ignored
    monitor_reset_next = lost && monitoring_reg && !paused;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg         <= clock_stop_monitor_pkg::mon_idle;
      monitoring_reg    <= 1'b0;
      monitor_reset_reg <= 1'b0;
    end else begin
      state_reg         <= state_next;
      monitoring_reg    <= monitoring_next;
      monitor_reset_reg <= monitor_reset_next;
    end
  end

  // ==========================================================================
  // loss detector
  // it runs only while active, so its count restarts after every pause
  x1_edge_detector loss_detect (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ring_tick_i (ring_tick_reg),
    .run_i       (monitoring_reg),
    .osc_i       (main_osc_clock_i),
    .lost_o      (lost)
  );

  // ==========================================================================
  // register read port
  // the upper seven bits always read zero; the data is registered so the
  // reader sees it one cycle after the address
  always_comb begin
    rd_data_next = 8'h00;
    if (rd_addr_i == clock_stop_monitor_pkg::mode_addr) begin
      rd_data_next = {7'h00, enable_reg};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg <= clock_stop_monitor_pkg::mode_reset;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign rd_data_o                  = rd_data_reg;
  assign monitor_enable_o           = enable_reg;
  assign monitoring_o               = monitoring_reg;
  assign monitor_reset_o            = monitor_reset_reg;
  assign monitor_reset_cause_flag_o = cause_reg;
  assign ring_running_o             = ring_running_reg;

  // ==========================================================================
  // assertions

  // upper mode bits never read as one
  a_high_bits_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_data_reg[7:1] == 7'h00
  ) else $error("mode register upper bits read nonzero");

  // enable stays set unless a reset of some kind arrives
  a_enable_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    enable_reg && !int_rst_i && !poc_rst_i && !monitor_reset_reg
    |=> enable_reg
  ) else $error("enable cleared without a reset");

  // a monitor reset clears enable and sets the cause flag
  a_reset_marks_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    monitor_reset_reg |=> !enable_reg && cause_reg
  ) else $error("monitor reset did not clear enable or set cause");

  // a loss while sampling and not paused always leads to a reset request
  a_loss_resets: assert property (
    @(posedge clk_i) disable iff (rst_i)
    monitoring_reg && lost && !paused |=> monitor_reset_reg
  ) else $error("loss while monitoring gave no reset");

  // no sampling in the cycle after a pause condition
  a_pause_stops: assert property (
    @(posedge clk_i) disable iff (rst_i)
    paused |=> !monitoring_reg
  ) else $error("monitoring active during a pause");

  // an enabled, waiting monitor starts once the pause ends
  a_wait_resumes: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_reg == clock_stop_monitor_pkg::mon_wait && !paused && enable_next
    |=> monitoring_reg
  ) else $error("monitor did not resume after pause");

  // without the build option the ring clock never stops
  a_ring_fixed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !RING_STOPPABLE |-> ring_running_reg
  ) else $error("ring clock stopped without build option");

endmodule : clock_stop_monitor

// ===== verif/osc_reset_model.sv
/* main oscillator and chip reset generator model.
   assumes the bench gates the oscillator and supplies the system clock. */
`timescale 1ns/1ps
module osc_reset_model (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic mon_rst_i,
  output logic      osc_o,
  output logic      int_rst_o
);
  // ==================
  // oscillator: a stopped crystal sits low, so the sampler sees no edge
  initial osc_o = 1'b0;
  always #20 osc_o = run_i ? ~osc_o : 1'b0;
  // reset generator turns a monitor request into an internal reset
  always_ff @(posedge clk_i) int_rst_o <= mon_rst_i;
endmodule : osc_reset_model

// ===== verif/clock_stop_monitor_tb.sv
/* self-checking bench: mode write table, then pause, loss and cause cases.
   assumes osc_reset_model drives the main clock and internal reset. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module clock_stop_monitor_tb;
  logic clk_i = 0, rst_i = 1, poc_rst_i = 0, run = 1, osc, irst, en, mon;
  logic mrst, flag, ring;
  logic [7:0] rd;
  int errors = 0, checks = 0, k;
  clock_stop_monitor_pkg::reg_write_type wr = '0;
  clock_stop_monitor_pkg::clock_status_type st = '0;
  logic [8:0] rows [4] = '{{8'hfe, 1'b0}, {8'h01, 1'b1}, {8'h00, 1'b0},
                           {8'h00, 1'b1}};
  logic [7:0] want [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  always #4 clk_i = ~clk_i;
  osc_reset_model M (.clk_i(clk_i), .run_i(run), .mon_rst_i(mrst),
    .osc_o(osc), .int_rst_o(irst));
  clock_stop_monitor #(.RING_STOPPABLE(1'b0), .RING_DIV(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .int_rst_i(irst), .poc_rst_i(poc_rst_i),
    .main_osc_clock_i(osc), .wr_i(wr),
    .rd_addr_i(clock_stop_monitor_pkg::mode_addr), .status_i(st),
    .rd_data_o(rd), .monitor_enable_o(en), .monitoring_o(mon),
    .monitor_reset_o(mrst), .monitor_reset_cause_flag_o(flag),
    .ring_running_o(ring));
  task automatic put(input logic [7:0] d, input logic b);
    @(negedge clk_i) wr <= '{1'b1, b, 3'h0,
      clock_stop_monitor_pkg::mode_addr, d};
    @(negedge clk_i) wr.wr <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : put
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #100us errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i <= 0;
    @(negedge clk_i) `CHK("mode", 8'h00, rd)
    // writes land while stabilization still runs, so no monitoring yet
    for (k = 0; k < 4; k++) begin
      put(rows[k][8:1], rows[k][0]);
      `CHK("mode", want[k], rd)
      `CHK("mon", 1'b0, mon)
    end
    $display("table done");
    st.stab_done <= 1;
    repeat (8) @(negedge clk_i) `CHK("mon", 1'b1, mon)
    st <= 5'b10000;
    run <= 0;
    repeat (40) @(negedge clk_i);
    `CHK("mon", 1'b0, mon)
    `CHK("rst", 1'b0, mrst)
    st <= 5'b01001;
    repeat (40) @(negedge clk_i) `CHK("mon", 1'b0, mon)
    run <= 1;
    st <= 5'b00010;
    repeat (8) @(negedge clk_i) `CHK("ring", 1'b1, ring)
    st.stab_done <= 1;
    repeat (8) @(negedge clk_i) `CHK("mon", 1'b1, mon)
    run <= 0;
    for (k = 0; k < 300 && mrst !== 1'b1; k++) @(negedge clk_i);
    `CHK("rst", 1'b1, mrst)
    repeat (4) @(negedge clk_i) `CHK("en", 1'b0, en)
    `CHK("flag", 1'b1, flag)
    poc_rst_i <= 1;
    repeat (2) @(negedge clk_i) poc_rst_i <= 0;
    @(negedge clk_i) `CHK("flag", 1'b0, flag)
    run <= 1;
    put(8'h01, 1'b1);
    `CHK("mon", 1'b1, mon)
    rst_i <= 1;
    @(negedge clk_i) rst_i <= 0;
    `CHK("en", 1'b0, en)
    @(negedge clk_i) `CHK("mode", 8'h00, rd)
    $display("pause and loss done");
    report_and_stop();
  end
endmodule : clock_stop_monitor_tb
